// file: sim/tb_tdm_port_rate_and_frame_timing.sv
`timescale 1ns/10ps
module tb_tdm_port_rate_and_frame_timing;
  import tdm_timing_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd_data;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, master_clock_in, master_frame_pulse_in;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, local_in_streams, backplane_in_streams;
  wire [31:0] local_out_streams, local_out_oe;
  wire [31:0] backplane_out_streams, backplane_out_oe;
  wire gen_clock_8m, gen_clock_16m, gen_frame_pulse_8m, gen_frame_pulse_16m;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  tdm_far_end u_far (.*);
  tdm_port_rate_and_frame_timing u_dut (.*);
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : cmp
  // generated pulses at a frame start: clock levels and pulse widths
  task automatic pulse_chk(input logic pol);
    int w8 = 0;
    int w16 = 0;
    @(negedge gen_frame_pulse_8m);
    @(posedge aclk);
    cmp({30'h0, gen_clock_8m, gen_clock_16m}, {30'h0, pol, pol});
    while (!gen_frame_pulse_8m)
    begin
      w8 += 1;
      w16 += 32'(!gen_frame_pulse_16m);
      @(posedge aclk);
    end
    cmp(32'(w8 >= 14 && w8 <= 17), 32'h0000_0001);
    cmp(32'(w16 >= 6 && w16 <= 9), 32'h0000_0001);
  endtask : pulse_chk
  task automatic end_sim(input int extra);
    fails += extra;
    $display("%0d compared, %0d wrong", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic xfer(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{wr}};
    {s_axi_arvalid, s_axi_rready} <= {2{!wr}};
    do
    begin
      @(posedge aclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
    end
    while (!(wr ? s_axi_bvalid : s_axi_rvalid));
    {s_axi_bready, s_axi_rready} <= 2'h0;
    rd_data = s_axi_rdata;
    cmp(32'(wr ? s_axi_bresp : s_axi_rresp), 32'(er));
  endtask : xfer
  always @(posedge aclk)
    if (++cyc == 95000)
      end_sim(1);
  initial
  begin
    aclk = 1'b0;
    forever
      #4 aclk = ~aclk;
  end
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid} = 3'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h00_0000_0000_0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    xfer(1'h0, CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    cmp(rd_data, 32'h0000_0000);
    xfer(1'h0, 12'h400, 32'h0000_0000, RESP_DECERR);
    xfer(1'h1, 12'h400, 32'h0000_0001, RESP_DECERR);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'h1, RATE_BASE_OFS + 12'(4 * i), 32'h0000_00e4, RESP_OKAY);
      xfer(1'h0, RATE_BASE_OFS + 12'(4 * i), 32'h0000_0000, RESP_OKAY);
      cmp(rd_data, 32'h0000_00e4);
    end
    xfer(1'h1, CONN_LOCAL_OFS, 32'h0000_0200, RESP_OKAY);
    xfer(1'h1, CONN_LOCAL_OFS + 12'h004, 32'h0000_0300, RESP_OKAY);
    xfer(1'h1, CONN_LOCAL_OFS + 12'h008, 32'h0000_0600, RESP_OKAY);
    xfer(1'h1, CONN_LOCAL_OFS + 12'h040, 32'h0000_0200, RESP_OKAY);
    xfer(1'h1, CONN_BP_OFS, 32'h0000_0300, RESP_OKAY);
    xfer(1'h1, CONN_BP_OFS + 12'h040, 32'h0000_0600, RESP_OKAY);
    repeat (52000) @(posedge aclk);
    xfer(1'h0, STATUS_OFS, 32'h0000_0000, RESP_OKAY);
    cmp(rd_data & 32'h0000_0003, 32'h0000_0002);
    cmp(local_out_oe, 32'h0001_0007);
    cmp(local_out_streams & 32'h0000_0007, 32'h0000_0004);
    cmp(backplane_out_oe, 32'h0001_0001);
    cmp(backplane_out_streams & 32'h0001_0001, 32'h0001_0000);
    xfer(1'h1, CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    repeat (2000) @(posedge aclk);
    cmp(local_out_oe, 32'h0000_0007);
    cmp(backplane_out_oe, 32'h0001_0001);
    pulse_chk(1'b0);
    xfer(1'h1, CTRL_OFS, 32'h0000_0013, RESP_OKAY);
    repeat (2000) @(posedge aclk);
    cmp(backplane_out_oe, 32'h0000_0001);
    cmp(local_out_oe, 32'h0000_0007);
    pulse_chk(1'b1);
    end_sim(0);
  end
endmodule : tb_tdm_port_rate_and_frame_timing

// file: sim/tdm_far_end.sv
`timescale 1ns/10ps
module tdm_far_end (
  output logic master_clock_in,
  output logic master_frame_pulse_in,
  output logic [31:0] local_in_streams,
  output logic [31:0] backplane_in_streams
);
  int n = 0;
  assign local_in_streams = 32'h0000_0000;
  assign backplane_in_streams = 32'hffff_ffff;
  initial
  begin
    master_clock_in = 1'b0;
    master_frame_pulse_in = 1'b1;
    forever
    begin
      #62.5 master_clock_in = !master_clock_in;
      if (master_clock_in)
        n = (n + 1) % 1024;
      // low one clock across the boundary
      master_frame_pulse_in = !(n == 0);
    end
  end
endmodule : tdm_far_end

// file: sim/tdm_timing_monitor.sv
`timescale 1ns/10ps
module tdm_timing_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] local_out_oe,
  input wire logic gen_frame_pulse_8m
);
  import tdm_timing_pkg::*;
  // ***********************************************
  // bus and reset checks
  // ***********************************************
  wire aw_go = s_axi_awvalid && s_axi_awready;
  wire w_go = s_axi_wvalid && s_axi_wready;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_wr_answer: assert property (aw_go && w_go |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("no read data");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  a_aw_blocked: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_b_cause: assert property ($rose(s_axi_bvalid)
    |-> !$past(s_axi_awready) && !$past(s_axi_wready))
    else $error("response without request");
  a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read data without request");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn
    |=> local_out_oe == 32'h0000_0000 && gen_frame_pulse_8m)
    else $error("outputs not idle after reset");
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rready);
  cover property (local_out_oe[16]);
endmodule : tdm_timing_monitor
bind tdm_port_rate_and_frame_timing tdm_timing_monitor u_mon (.*);

// file: src/tdm_port_rate_and_frame_timing.sv
`timescale 1ns/10ps
module tdm_port_rate_and_frame_timing (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic master_clock_in,
  input wire logic master_frame_pulse_in,
  input wire logic [tdm_timing_pkg::STREAMS-1:0] local_in_streams,
  input wire logic [tdm_timing_pkg::STREAMS-1:0] backplane_in_streams,
  output logic [tdm_timing_pkg::STREAMS-1:0] local_out_streams,
  output logic [tdm_timing_pkg::STREAMS-1:0] local_out_oe,
  output logic [tdm_timing_pkg::STREAMS-1:0] backplane_out_streams,
  output logic [tdm_timing_pkg::STREAMS-1:0] backplane_out_oe,
  output logic gen_clock_8m,
  output logic gen_clock_16m,
  output logic gen_frame_pulse_8m,
  output logic gen_frame_pulse_16m
);
  import tdm_timing_pkg::*;

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [CTRL_W-1:0] ctrl;
  logic [1:0] rate [BANKS][STREAMS];
  logic [CONN_W-1:0] conn_local [STREAMS];
  logic [CONN_W-1:0] conn_bp [STREAMS];
  logic [31:0] rate_word [BANKS][2];
  logic style_gci;
  logic locked;
  logic [15:0] frame_count;

  wire local_wide_mode = ctrl[CTRL_LOCAL_WIDE];
  wire backplane_wide_mode = ctrl[CTRL_BP_WIDE];
  wire frame_pulse_width_sel = ctrl[CTRL_FPW];
  wire input_clock_edge_sel = ctrl[CTRL_CLK_EDGE];
  wire output_clock_polarity_sel = ctrl[CTRL_OUT_POL];

  function automatic logic [31:0] merge_bytes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  for (genvar b = 0; b < BANKS; b++)
  begin : g_pack_bank
    for (genvar k = 0; k < WIDE_STREAMS; k++)
    begin : g_pack
      assign rate_word[b][0][2*k +: 2] = rate[b][k];
      assign rate_word[b][1][2*k +: 2] = rate[b][k + WIDE_STREAMS];
    end
  end

  // ***************************************************************
  // axi4-lite write channel
  // ***************************************************************
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  wire do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ctrl = wr_addr[11:2] == CTRL_OFS[11:2];
  wire wr_rate = wr_addr >= RATE_BASE_OFS && wr_addr < RATE_END_OFS;
  wire wr_conn_l = wr_addr >= CONN_LOCAL_OFS && wr_addr < CONN_BP_OFS;
  wire wr_conn_b = wr_addr >= CONN_BP_OFS && wr_addr < CONN_END_OFS;
  wire wr_stat = wr_addr[11:2] == STATUS_OFS[11:2];
  wire wr_hit = wr_ctrl || wr_rate || wr_conn_l || wr_conn_b || wr_stat;
  wire [11:0] wr_rate_rel = wr_addr - RATE_BASE_OFS;
  wire [1:0] wr_bank = wr_rate_rel[4:3];
  wire wr_half = wr_rate_rel[2];
  wire [4:0] wr_idx = wr_addr[6:2];
  wire [31:0] wr_rate_merged =
    merge_bytes(rate_word[wr_bank][wr_half], wr_data, wr_strb);
  wire [31:0] wr_ctrl_merged =
    merge_bytes({27'h000_0000, ctrl}, wr_data, wr_strb);
  wire [31:0] wr_connl_merged =
    merge_bytes({21'h00_0000, conn_local[wr_idx]}, wr_data, wr_strb);
  wire [31:0] wr_connb_merged =
    merge_bytes({21'h00_0000, conn_bp[wr_idx]}, wr_data, wr_strb);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      wr_addr <= 12'h000;
      wr_data <= 32'h0000_0000;
      wr_strb <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= CTRL_RESET;
      for (int s = 0; s < STREAMS; s++)
      begin
        conn_local[s] <= CONN_RESET;
        conn_bp[s] <= CONN_RESET;
        for (int b = 0; b < BANKS; b++)
        begin
          rate[b][s] <= RATE_2M;
        end
      end
    end
    else if (do_write)
    begin
      if (wr_ctrl)
      begin
        ctrl <= wr_ctrl_merged[CTRL_W-1:0];
      end
      if (wr_conn_l)
      begin
        conn_local[wr_idx] <= wr_connl_merged[CONN_W-1:0];
      end
      if (wr_conn_b)
      begin
        conn_bp[wr_idx] <= wr_connb_merged[CONN_W-1:0];
      end
      if (wr_rate)
      begin
        for (int k = 0; k < WIDE_STREAMS; k++)
        begin
          rate[wr_bank][k + WIDE_STREAMS * 32'(wr_half)] <=
            wr_rate_merged[2*k +: 2];
        end
      end
    end
  end

  // ***************************************************************
  // axi4-lite read channel
  // ***************************************************************
  wire rd_ctrl = s_axi_araddr[11:2] == CTRL_OFS[11:2];
  wire rd_stat = s_axi_araddr[11:2] == STATUS_OFS[11:2];
  wire rd_rate = s_axi_araddr >= RATE_BASE_OFS &&
    s_axi_araddr < RATE_END_OFS;
  wire rd_conn_l = s_axi_araddr >= CONN_LOCAL_OFS &&
    s_axi_araddr < CONN_BP_OFS;
  wire rd_conn_b = s_axi_araddr >= CONN_BP_OFS &&
    s_axi_araddr < CONN_END_OFS;
  wire rd_hit = rd_ctrl || rd_stat || rd_rate || rd_conn_l || rd_conn_b;
  wire [11:0] rd_rate_rel = s_axi_araddr - RATE_BASE_OFS;
  wire [4:0] rd_idx = s_axi_araddr[6:2];
  wire [31:0] status_word = {frame_count, 14'h0000, locked, style_gci};
  wire [31:0] rd_data =
    rd_ctrl ? {27'h000_0000, ctrl} :
    rd_stat ? status_word :
    rd_rate ? rate_word[rd_rate_rel[4:3]][rd_rate_rel[2]] :
    rd_conn_l ? {21'h00_0000, conn_local[rd_idx]} :
    rd_conn_b ? {21'h00_0000, conn_bp[rd_idx]} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***************************************************************
  // pin synchronisers and master clock edges
  // ***************************************************************
  logic [65:0] sync1;
  logic [65:0] sync2;
  logic mclk_prev;
  wire mclk = sync2[64];
  wire fp_level = sync2[65];
  wire [STREAMS-1:0] local_in = sync2[31:0];
  wire [STREAMS-1:0] bp_in = sync2[63:32];
  wire mclk_rise = mclk && !mclk_prev;
  wire mclk_fall = !mclk && mclk_prev;
  wire active_edge = input_clock_edge_sel ? mclk_rise : mclk_fall;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1 <= '0;
      sync2 <= '0;
      mclk_prev <= 1'b0;
    end
    else
    begin
      sync1 <= {master_frame_pulse_in, master_clock_in,
        backplane_in_streams, local_in_streams};
      sync2 <= sync1;
      mclk_prev <= mclk;
    end
  end

  // ***************************************************************
  // clock multiplier: quarter-period ticks from measured period
  // ***************************************************************
  logic [PERIOD_W-1:0] period_cnt;
  logic [PERIOD_W-1:0] period;
  logic [1:0] quarter;
  wire [PERIOD_W-1:0] next_period_cnt =
    period_cnt == PERIOD_MAX ? period_cnt : period_cnt + 6'h01;
  wire [PERIOD_W+1:0] three_q = 8'(period) * 8'h03;
  wire q_tick = !active_edge && quarter != 2'h3 && (
    (quarter == 2'h0 && next_period_cnt == (period >> 2)) ||
    (quarter == 2'h1 && next_period_cnt == (period >> 1)) ||
    (quarter == 2'h2 && next_period_cnt == three_q[PERIOD_W+1:2]));
  wire tick = active_edge || q_tick;
  wire [1:0] tick_phase = active_edge ? 2'h0 : quarter + 2'h1;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      period_cnt <= '0;
      period <= PERIOD_RESET;
      quarter <= 2'h0;
    end
    else if (active_edge)
    begin
      period <= next_period_cnt;
      period_cnt <= '0;
      quarter <= 2'h0;
    end
    else
    begin
      period_cnt <= next_period_cnt;
      if (q_tick)
      begin
        quarter <= tick_phase;
      end
    end
  end

  // ***************************************************************
  // frame pulse style detection and frame boundary
  // ***************************************************************
  logic idle_level;
  logic [2:0] run_len;
  logic [1:0] pulse_len;
  logic [9:0] clk_cnt;
  wire fp_active = fp_level != idle_level;
  wire [1:0] fp_edges =
    frame_pulse_width_sel ? FP_WIDE_EDGES : FP_NARROW_EDGES;
  wire frame_start = active_edge && fp_active &&
    pulse_len + 2'h1 == fp_edges;
  wire [9:0] next_clk_cnt = frame_start ? 10'h000 : clk_cnt + 10'h001;
  // count of the clock that the current tick falls in
  wire [9:0] tick_cnt = active_edge ? next_clk_cnt : clk_cnt;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      idle_level <= 1'b1;
      run_len <= 3'h0;
      pulse_len <= 2'h0;
      clk_cnt <= 10'h000;
      style_gci <= 1'b0;
      locked <= 1'b0;
      frame_count <= 16'h0000;
    end
    else if (active_edge)
    begin
      clk_cnt <= next_clk_cnt;
      pulse_len <= fp_active && pulse_len != 2'h3 ?
        pulse_len + 2'h1 : 2'h0;
      if (fp_level == idle_level)
      begin
        run_len <= 3'h0;
      end
      else if (run_len + 3'h1 == IDLE_EDGES)
      begin
        idle_level <= fp_level;
        style_gci <= !fp_level;
        run_len <= 3'h0;
      end
      else
      begin
        run_len <= run_len + 3'h1;
      end
      if (frame_start)
      begin
        locked <= 1'b1;
        frame_count <= frame_count + 16'h0001;
      end
    end
  end

  // ***************************************************************
  // generated clocks and frame pulses
  // ***************************************************************
  wire [9:0] fp_out_clocks = {8'h00, fp_edges};

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gen_clock_8m <= 1'b0;
      gen_clock_16m <= 1'b0;
      gen_frame_pulse_8m <= 1'b1;
      gen_frame_pulse_16m <= 1'b1;
    end
    else
    begin
      gen_clock_8m <= mclk ^ input_clock_edge_sel ^
        output_clock_polarity_sel;
      if (active_edge)
      begin
        gen_clock_16m <= output_clock_polarity_sel;
      end
      else if (q_tick)
      begin
        gen_clock_16m <= !gen_clock_16m;
      end
      if (tick)
      begin
        gen_frame_pulse_8m <= (locked && tick_cnt < fp_out_clocks) ?
          style_gci : !style_gci;
        gen_frame_pulse_16m <= (locked && tick_cnt == 10'h000 &&
          (frame_pulse_width_sel || !tick_phase[1])) ?
          style_gci : !style_gci;
      end
    end
  end

  // ***************************************************************
  // per-stream bit timing, capture and transmit
  // ***************************************************************
  function automatic logic bit_due(
    input logic [1:0] code,
    input logic wide,
    input logic unused,
    input logic [1:0] phase,
    input logic [1:0] clk_lsb
  );
    logic due;
    due = 1'b0;
    if (unused)
    begin
      due = 1'b0;
    end
    else if (wide)
    begin
      due = 1'b1;
    end
    else
    begin
      case (code)
        RATE_16M: due = !phase[0];
        RATE_8M: due = phase == 2'h0;
        RATE_4M: due = phase == 2'h0 && !clk_lsb[0];
        RATE_2M: due = phase == 2'h0 && clk_lsb == 2'h0;
        default: due = 1'b0;
      endcase
    end
    return due;
  endfunction : bit_due

  for (genvar s = 0; s < STREAMS; s++)
  begin : g_stream
    localparam bit UPPER = s >= WIDE_STREAMS;
    logic [7:0] lin_sh;
    logic [7:0] bin_sh;
    logic [7:0] lin_byte [3];
    logic [7:0] bin_byte [3];
    logic [7:0] lout_sh;
    logic [7:0] bout_sh;
    logic [2:0] lin_bits;
    logic [2:0] bin_bits;
    logic [2:0] lout_bits;
    logic [2:0] bout_bits;
    wire l_unused = local_wide_mode && UPPER;
    wire b_unused = backplane_wide_mode && UPPER;
    wire lin_due = tick && bit_due(rate[BANK_LOCAL_IN][s], local_wide_mode,
      l_unused, tick_phase, next_clk_cnt[1:0]);
    wire bin_due = tick && bit_due(rate[BANK_BP_IN][s], backplane_wide_mode,
      b_unused, tick_phase, next_clk_cnt[1:0]);
    wire lout_due = tick && bit_due(rate[BANK_LOCAL_OUT][s],
      local_wide_mode, l_unused, tick_phase, next_clk_cnt[1:0]);
    wire bout_due = tick && bit_due(rate[BANK_BP_OUT][s],
      backplane_wide_mode, b_unused, tick_phase, next_clk_cnt[1:0]);
    wire [7:0] l_conn_data = conn_local[s][CONN_SRC] ?
      bin_byte[2] : lin_byte[2];
    wire [7:0] l_next = conn_local[s][CONN_MSG_SEL] ?
      conn_local[s][CONN_MSG_LSB +: 8] : l_conn_data;
    wire [7:0] b_conn_data = conn_bp[s][CONN_SRC] ?
      bin_byte[2] : lin_byte[2];
    wire [7:0] b_next = conn_bp[s][CONN_MSG_SEL] ?
      conn_bp[s][CONN_MSG_LSB +: 8] : b_conn_data;

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        lin_sh <= 8'h00;
        bin_sh <= 8'h00;
        lout_sh <= 8'hff;
        bout_sh <= 8'hff;
        lin_bits <= 3'h0;
        bin_bits <= 3'h0;
        lout_bits <= 3'h0;
        bout_bits <= 3'h0;
        for (int k = 0; k < 3; k++)
        begin
          lin_byte[k] <= 8'hff;
          bin_byte[k] <= 8'hff;
        end
        local_out_streams[s] <= 1'b1;
        backplane_out_streams[s] <= 1'b1;
        local_out_oe[s] <= 1'b0;
        backplane_out_oe[s] <= 1'b0;
      end
      else
      begin
        if (lin_due)
        begin
          lin_sh <= {lin_sh[6:0], local_in[s]};
          lin_bits <= frame_start ? 3'h1 : lin_bits + 3'h1;
          if (lin_bits == 3'h7)
          begin
            lin_byte[0] <= {lin_sh[6:0], local_in[s]};
          end
        end
        if (bin_due)
        begin
          bin_sh <= {bin_sh[6:0], bp_in[s]};
          bin_bits <= frame_start ? 3'h1 : bin_bits + 3'h1;
          if (bin_bits == 3'h7)
          begin
            bin_byte[0] <= {bin_sh[6:0], bp_in[s]};
          end
        end
        if (frame_start)
        begin
          lin_byte[1] <= lin_byte[0];
          lin_byte[2] <= lin_byte[1];
          bin_byte[1] <= bin_byte[0];
          bin_byte[2] <= bin_byte[1];
        end
        if (lout_due)
        begin
          lout_bits <= frame_start ? 3'h1 : lout_bits + 3'h1;
          local_out_streams[s] <= (frame_start || lout_bits == 3'h0) ?
            l_next[7] : lout_sh[7];
          lout_sh <= (frame_start || lout_bits == 3'h0) ?
            {l_next[6:0], 1'b1} : {lout_sh[6:0], 1'b1};
        end
        if (bout_due)
        begin
          bout_bits <= frame_start ? 3'h1 : bout_bits + 3'h1;
          backplane_out_streams[s] <= (frame_start || bout_bits == 3'h0) ?
            b_next[7] : bout_sh[7];
          bout_sh <= (frame_start || bout_bits == 3'h0) ?
            {b_next[6:0], 1'b1} : {bout_sh[6:0], 1'b1};
        end
        local_out_oe[s] <= locked && !l_unused &&
          conn_local[s][CONN_OE];
        backplane_out_oe[s] <= locked && !b_unused &&
          conn_bp[s][CONN_OE];
      end
    end
  end

endmodule : tdm_port_rate_and_frame_timing

// file: src/tdm_timing_pkg.sv
package tdm_timing_pkg;

  // ***************************************************************
  // port geometry
  // ***************************************************************
  localparam int STREAMS = 32;
  localparam int WIDE_STREAMS = 16;
  localparam int BANKS = 4;
  localparam int BANK_LOCAL_IN = 0;
  localparam int BANK_LOCAL_OUT = 1;
  localparam int BANK_BP_IN = 2;
  localparam int BANK_BP_OUT = 3;

  // ***************************************************************
  // register map (byte addresses)
  // ***************************************************************
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] RATE_BASE_OFS = 12'h010;
  localparam logic [11:0] RATE_END_OFS = 12'h030;
  localparam logic [11:0] CONN_LOCAL_OFS = 12'h100;
  localparam logic [11:0] CONN_BP_OFS = 12'h180;
  localparam logic [11:0] CONN_END_OFS = 12'h200;

  localparam int CTRL_LOCAL_WIDE = 0;
  localparam int CTRL_BP_WIDE = 1;
  localparam int CTRL_FPW = 2;
  localparam int CTRL_CLK_EDGE = 3;
  localparam int CTRL_OUT_POL = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h00;

  localparam int CONN_MSG_LSB = 0;
  localparam int CONN_MSG_SEL = 8;
  localparam int CONN_OE = 9;
  localparam int CONN_SRC = 10;
  localparam int CONN_W = 11;
  localparam logic [10:0] CONN_RESET = 11'h000;

  localparam int STATUS_GCI = 0;
  localparam int STATUS_LOCKED = 1;
  localparam int STATUS_FRAMES_LSB = 16;

  // ***************************************************************
  // rate codes, ascending
  // ***************************************************************
  localparam logic [1:0] RATE_2M = 2'h0;
  localparam logic [1:0] RATE_4M = 2'h1;
  localparam logic [1:0] RATE_8M = 2'h2;
  localparam logic [1:0] RATE_16M = 2'h3;

  // ***************************************************************
  // timing
  // ***************************************************************
  localparam int ACLK_NS = 8;
  localparam int MCLK_PERIOD_NS = 122;
  localparam int FP_NARROW_NS = 122;
  localparam int FP_WIDE_NS = 244;
  localparam logic [1:0] FP_NARROW_EDGES = 2'(FP_NARROW_NS / MCLK_PERIOD_NS);
  localparam logic [1:0] FP_WIDE_EDGES = 2'(FP_WIDE_NS / MCLK_PERIOD_NS);
  localparam logic [2:0] IDLE_EDGES = 3'h4;
  localparam int PERIOD_W = 6;
  localparam logic [5:0] PERIOD_MAX = 6'h3f;
  localparam logic [5:0] PERIOD_RESET =
    6'((MCLK_PERIOD_NS + ACLK_NS - 1) / ACLK_NS);
  localparam int FRAME_CLOCKS = 1024;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : tdm_timing_pkg
